// ---- design/sctc_pkg.sv ----
package sctc_pkg;

	// ------------------------------------------------------------
	// Field positions and widths
	// ------------------------------------------------------------
	localparam int SEL_LO         = 16;
	localparam int SEL_HI         = 20;
	localparam int SEL_W          = 5;
	localparam int CTR_W          = 32;
	localparam int WLE_W          = 4;
	localparam int FLE_W          = 6;
	localparam int FLE_UPD_W      = 5;
	localparam int HOLD_DELAY_SETTING_W         = 6;
	localparam int CNT_W          = 8;

	// ------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------
	localparam logic [CTR_W-1:0] CTR_RST     = 32'h0000_0000;
	localparam logic [WLE_W-1:0] WLE_RST     = 4'h7;
	localparam logic [FLE_W-1:0] FLE_RST     = 6'h07;
	localparam logic [HOLD_DELAY_SETTING_W-1:0] HOLD_DELAY_SETTING_RST   = 6'h00;
	localparam int   SYS_PERIOD_PS           = 25000;
	localparam int   HOLD_DELAY_SETTING_ZERO_CLKS          = 4;
	localparam logic [CNT_W-1:0] LEAD_CLKS   = 8'h02;
	localparam logic [CNT_W-1:0] TRAIL_CLKS  = 8'h02;
	localparam logic [CNT_W-1:0] NEXTF_CLKS  = 8'h02;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [SEL_W-1:0] sel;
		logic [WLE_W-1:0] bwle;
	} sctc_bypass_s;

	typedef struct packed {
		logic select_update_mode;
		logic word_length_update_mode;
		logic frame_length_update_mode;
	} sctc_upd_mode_s;

	typedef struct packed {
		logic                sof;
		logic                eof;
		logic [WLE_W-1:0]    wle;
		logic [FLE_W-1:0]    fle;
		logic [CTR_W-1:0]    ctr;
	} sctc_tx_param_s;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} sctc_word_s;

endpackage

// ---- design/sctc_link.sv ----
`timescale 1ns/1ps
`default_nettype none
// Link-clock shifter: toggle handshake in, toggle done out
module sctc_link
(
	input  wire logic          clk_link,
	input  wire logic          reset_link,
	input  wire logic          go_tgl,
	input  wire logic [7:0]    word,
	input  wire logic [3:0]    bits_m1,
	output logic               sdo,
	output logic               done_tgl
);

	// ------------------------------------------------------------
	// Crossing of request toggle
	// ------------------------------------------------------------
	logic go_s1_r;
	logic go_s2_r;
	logic go_s3_r;
	logic [7:0] sh_r;
	logic [7:0] sh_nxt;
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	logic       busy_r;
	logic       busy_nxt;
	logic       done_r;
	logic       done_nxt;

	always_comb
	begin
		sh_nxt   = sh_r;
		cnt_nxt  = cnt_r;
		busy_nxt = busy_r;
		done_nxt = done_r;
		if (busy_r)
		begin
			sh_nxt = {sh_r[6:0], 1'b0};
			if (cnt_r == 4'h0)
			begin
				busy_nxt = 1'b0;
				done_nxt = ~done_r;
			end
			else
				cnt_nxt = cnt_r - 4'h1;
		end
		else if (go_s3_r != go_s2_r)
		begin
			sh_nxt   = word;
			cnt_nxt  = bits_m1;
			busy_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_link)
	begin
		if (reset_link)
		begin
			go_s1_r <= 1'b0;
			go_s2_r <= 1'b0;
			go_s3_r <= 1'b0;
			sh_r    <= 8'h00;
			cnt_r   <= 4'h0;
			busy_r  <= 1'b0;
			done_r  <= 1'b0;
		end
		else
		begin
			go_s1_r <= go_tgl;
			go_s2_r <= go_s1_r;
			go_s3_r <= go_s2_r;
			sh_r    <= sh_nxt;
			cnt_r   <= cnt_nxt;
			busy_r  <= busy_nxt;
			done_r  <= done_nxt;
		end
	end

	assign sdo      = sh_r[7];
	assign done_tgl = done_r;

endmodule
`default_nettype wire

// ---- design/sctc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
//Contract
// - A bypass load into the transmit buffer hands control information to the channel.
// - Select-update mode copies bypass select into protocol control bits 20..16, synchronous mode only.
// - Word-length-update mode updates word length from bypass word length and sets end-of-frame.
// - Frame-length-update mode updates frame length bits 4..0 from bypass word length.
// - With all update modes clear, a bypass load changes no transmit parameter.
// - Writing 1 to the clear bit drops master select status at once, unless a frame start in idle sets it in the same cycle.
// - Select output drops after the running word and the trailing delay; the next-frame delay follows.
// - Transmit shift indication flag is set once a running word completes.
// - Nonzero hold delay uses the delay counter; zero gives four system clocks.
// - Slave receiver takes rates to system clock; half when frame lengths differ.
module sctc_top
(
	input  wire logic                          clk_sys,
	input  wire logic                          reset,
	input  wire logic                          clk_link,
	input  wire logic                          reset_link,
	input  wire logic                          synchronous_serial_mode,
	input  wire logic                          two_wire_bus_mode,
	input  wire sctc_pkg::sctc_upd_mode_s      upd_mode,
	input  wire logic                          bypass_load,
	input  wire sctc_pkg::sctc_bypass_s        bypass_in,
	input  wire logic                          transmit_buffer_wr,
	input  wire logic [7:0]                    transmit_buffer_data,
	input  wire logic                          frame_start,
	input  wire logic                          status_clear_msls,
	input  wire logic                          tsif_clear,
	input  wire logic [sctc_pkg::HOLD_DELAY_SETTING_W-1:0]   hold_delay_setting,
	input  wire logic                          ack_end,
	input  wire logic [sctc_pkg::FLE_W-1:0]    master_frame_length,
	output sctc_pkg::sctc_tx_param_s           tx_param,
	output logic                               master_select_status,
	output logic                               slave_select_output,
	output logic                               transmit_shift_indication_flag,
	output logic                               sda_out,
	output logic                               sda_oe,
	output logic                               sdo,
	output logic                               slave_full_rate
);

	// ------------------------------------------------------------
	// Transmit parameters and bypass update
	// ------------------------------------------------------------
	sctc_pkg::sctc_tx_param_s par_r;
	sctc_pkg::sctc_tx_param_s par_nxt;

	always_comb
	begin
		par_nxt = par_r;
		if (bypass_load)
		begin
			if (upd_mode.select_update_mode && synchronous_serial_mode)
				par_nxt.ctr[sctc_pkg::SEL_HI:sctc_pkg::SEL_LO] = bypass_in.sel;
			if (upd_mode.word_length_update_mode)
			begin
				par_nxt.wle = bypass_in.bwle;
				par_nxt.eof = 1'b1;
			end
			if (upd_mode.frame_length_update_mode)
				par_nxt.fle[sctc_pkg::FLE_UPD_W-1:0] = {1'b0, bypass_in.bwle};
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			par_r.sof <= 1'b0;
			par_r.eof <= 1'b0;
			par_r.wle <= sctc_pkg::WLE_RST;
			par_r.fle <= sctc_pkg::FLE_RST;
			par_r.ctr <= sctc_pkg::CTR_RST;
		end
		else
			par_r <= par_nxt;
	end

	assign tx_param = par_r;

	// ------------------------------------------------------------
	// Crossing to and from the link shifter
	// ------------------------------------------------------------
	logic       go_tgl_r;
	logic       go_tgl_nxt;
	logic [7:0] word_r;
	logic [7:0] word_nxt;
	logic       dn_tgl;
	logic       dn_s1_r;
	logic       dn_s2_r;
	logic       dn_s3_r;
	logic       word_done;
	logic       sdo_link;
	logic       sdo_s1_r;
	logic       sdo_s2_r;

	sctc_link u_link
	(
		.clk_link   (clk_link),
		.reset_link (reset_link),
		.go_tgl     (go_tgl_r),
		.word       (word_r),
		.bits_m1    (par_r.wle),
		.sdo        (sdo_link),
		.done_tgl   (dn_tgl)
	);
	assign word_done = dn_s3_r != dn_s2_r;

	// ------------------------------------------------------------
	// Select sequencer
	// ------------------------------------------------------------
	typedef enum logic [2:0] {SS_IDLE, SS_LEAD, SS_XFER, SS_TRAIL, SS_NEXT} sctc_ss_e;
	sctc_ss_e             ss_r;
	sctc_ss_e             ss_nxt;
	logic [sctc_pkg::CNT_W-1:0] cnt_r;
	logic [sctc_pkg::CNT_W-1:0] cnt_nxt;
	logic                 msls_r;
	logic                 msls_nxt;
	logic                 sel_r;
	logic                 sel_nxt;
	logic                 tsif_r;
	logic                 tsif_nxt;
	logic                 pend_r;
	logic                 pend_nxt;

	always_comb
	begin
		ss_nxt     = ss_r;
		cnt_nxt    = cnt_r;
		msls_nxt   = msls_r;
		sel_nxt    = sel_r;
		go_tgl_nxt = go_tgl_r;
		word_nxt   = word_r;
		pend_nxt   = pend_r;
		tsif_nxt   = tsif_r;
		if (tsif_clear)
			tsif_nxt = 1'b0;
		if (word_done)
			tsif_nxt = 1'b1;
		if (transmit_buffer_wr)
		begin
			pend_nxt = 1'b1;
			word_nxt = transmit_buffer_data;
		end
		if (status_clear_msls)
			msls_nxt = 1'b0;
		unique case (ss_r)
			SS_IDLE:
				if (frame_start && synchronous_serial_mode)
				begin
					msls_nxt = 1'b1;
					sel_nxt  = 1'b1;
					cnt_nxt  = sctc_pkg::LEAD_CLKS;
					ss_nxt   = SS_LEAD;
				end
			SS_LEAD:
				if (status_clear_msls || !msls_r)
				begin
					cnt_nxt = sctc_pkg::TRAIL_CLKS;
					ss_nxt  = SS_TRAIL;
				end
				else if (cnt_r != '0)
					cnt_nxt = cnt_r - 8'h01;
				else if (pend_r)
				begin
					go_tgl_nxt = ~go_tgl_r;
					pend_nxt   = 1'b0;
					ss_nxt     = SS_XFER;
				end
			SS_XFER:
				if (word_done)
				begin
					if (!msls_nxt || par_r.eof)
					begin
						msls_nxt = 1'b0;
						cnt_nxt  = sctc_pkg::TRAIL_CLKS;
						ss_nxt   = SS_TRAIL;
					end
					else
						ss_nxt  = SS_LEAD;
				end
			SS_TRAIL:
				if (cnt_r != '0)
					cnt_nxt = cnt_r - 8'h01;
				else
				begin
					sel_nxt = 1'b0;
					cnt_nxt = sctc_pkg::NEXTF_CLKS;
					ss_nxt  = SS_NEXT;
				end
			SS_NEXT:
				if (cnt_r != '0)
					cnt_nxt = cnt_r - 8'h01;
				else
					ss_nxt = SS_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			ss_r     <= SS_IDLE;
			cnt_r    <= '0;
			msls_r   <= 1'b0;
			sel_r    <= 1'b0;
			tsif_r   <= 1'b0;
			pend_r   <= 1'b0;
			go_tgl_r <= 1'b0;
			word_r   <= 8'h00;
			dn_s1_r  <= 1'b0;
			dn_s2_r  <= 1'b0;
			dn_s3_r  <= 1'b0;
			sdo_s1_r <= 1'b0;
			sdo_s2_r <= 1'b0;
		end
		else
		begin
			ss_r     <= ss_nxt;
			cnt_r    <= cnt_nxt;
			msls_r   <= msls_nxt;
			sel_r    <= sel_nxt;
			tsif_r   <= tsif_nxt;
			pend_r   <= pend_nxt;
			go_tgl_r <= go_tgl_nxt;
			word_r   <= word_nxt;
			dn_s1_r  <= dn_tgl;
			dn_s2_r  <= dn_s1_r;
			dn_s3_r  <= dn_s2_r;
			sdo_s1_r <= sdo_link;
			sdo_s2_r <= sdo_s1_r;
		end
	end

	assign master_select_status           = msls_r;
	assign slave_select_output            = sel_r;
	assign transmit_shift_indication_flag = tsif_r;
	assign sdo                            = sdo_s2_r;

	// ------------------------------------------------------------
	// Two-wire data hold delay
	// ------------------------------------------------------------
	logic [sctc_pkg::HOLD_DELAY_SETTING_W:0] hd_r;
	logic [sctc_pkg::HOLD_DELAY_SETTING_W:0] hd_nxt;
	logic [7:0]                iic_sh_r;
	logic [7:0]                iic_sh_nxt;
	logic [3:0]                iic_bits_r;
	logic [3:0]                iic_bits_nxt;
	logic                      sda_r;
	logic                      sda_nxt;
	logic                      oe_r;
	logic                      oe_nxt;
	logic                      arm_r;
	logic                      arm_nxt;
	logic                      full_r;
	logic                      full_nxt;

	always_comb
	begin
		hd_nxt       = hd_r;
		iic_sh_nxt   = iic_sh_r;
		iic_bits_nxt = iic_bits_r;
		sda_nxt      = sda_r;
		oe_nxt       = oe_r;
		arm_nxt      = arm_r;
		if (two_wire_bus_mode && transmit_buffer_wr && iic_bits_r == 4'h0)
		begin
			iic_sh_nxt   = transmit_buffer_data;
			iic_bits_nxt = 4'h8;
		end
		if (!two_wire_bus_mode)
		begin
			oe_nxt  = 1'b0;
			sda_nxt = 1'b1;
		end
		else if (ack_end)
		begin
			hd_nxt  = (hold_delay_setting == '0) ? 7'(sctc_pkg::HOLD_DELAY_SETTING_ZERO_CLKS) : {1'b0, hold_delay_setting};
			arm_nxt = 1'b1;
		end
		else if (hd_r != '0)
			hd_nxt = hd_r - 7'h01;
		else if (arm_r && iic_bits_r != 4'h0)
		begin
			sda_nxt      = iic_sh_r[7];
			oe_nxt       = 1'b1;
			iic_sh_nxt   = {iic_sh_r[6:0], 1'b1};
			iic_bits_nxt = iic_bits_r - 4'h1;
			arm_nxt      = iic_bits_r != 4'h1;
		end
		else
			oe_nxt = 1'b0;
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			hd_r       <= '0;
			iic_sh_r   <= 8'hff;
			iic_bits_r <= 4'h0;
			sda_r      <= 1'b1;
			oe_r       <= 1'b0;
			arm_r      <= 1'b0;
		end
		else
		begin
			hd_r       <= hd_nxt;
			iic_sh_r   <= iic_sh_nxt;
			iic_bits_r <= iic_bits_nxt;
			sda_r      <= sda_nxt;
			oe_r       <= oe_nxt;
			arm_r      <= arm_nxt;
		end
	end

	assign sda_out = sda_r;
	assign sda_oe  = oe_r;

	// ------------------------------------------------------------
	// Slave receiver rate indication
	// ------------------------------------------------------------
	always_comb
		full_nxt = (master_frame_length == par_r.fle);

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			full_r <= 1'b1;
		else
			full_r <= full_nxt;
	end

	assign slave_full_rate = full_r;

endmodule
`default_nettype wire

// ---- testbench/sctc_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module sctc_checker
(
	input wire logic                        clk_sys,
	input wire logic                        reset,
	input wire logic                        synchronous_serial_mode,
	input wire logic                        two_wire_bus_mode,
	input wire sctc_pkg::sctc_upd_mode_s    upd_mode,
	input wire logic                        bypass_load,
	input wire sctc_pkg::sctc_bypass_s      bypass_in,
	input wire logic                        status_clear_msls,
	input wire logic [sctc_pkg::HOLD_DELAY_SETTING_W-1:0] hold_delay_setting,
	input wire logic                        ack_end,
	input wire logic [sctc_pkg::FLE_W-1:0]  master_frame_length,
	input wire sctc_pkg::sctc_tx_param_s    tx_param,
	input wire logic                        master_select_status,
	input wire logic                        slave_select_output,
	input wire logic                        sda_oe,
	input wire logic                        slave_full_rate
);
	// ----------------
	// Port properties
	// ----------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	chk_sel_copy: assert property (bypass_load && synchronous_serial_mode && upd_mode.select_update_mode |=>
		tx_param.ctr[20:16] == $past(bypass_in.sel)) else $error("select field not copied");
	chk_wle_copy: assert property (bypass_load && upd_mode.word_length_update_mode |=>
		tx_param.wle == $past(bypass_in.bwle) && tx_param.eof) else $error("word length not copied");
	chk_fle_copy: assert property (bypass_load && upd_mode.frame_length_update_mode |=>
		tx_param.fle[4:0] == {1'b0, $past(bypass_in.bwle)}) else $error("frame length not copied");
	chk_no_update: assert property (bypass_load && upd_mode == 3'h0 |=> $stable(tx_param))
		else $error("parameters changed");
	chk_msls_clear: assert property (status_clear_msls |=> !master_select_status)
		else $error("select status not cleared");
	chk_sel_drop: assert property ($fell(master_select_status) |-> ##[1:400] !slave_select_output)
		else $error("select output stuck");
	chk_next_gap: assert property ($fell(slave_select_output) |-> !slave_select_output[*3])
		else $error("next frame gap short");
	chk_hold_zero: assert property (two_wire_bus_mode && ack_end && hold_delay_setting == 6'h00 |=>
		!sda_oe[*3]) else $error("hold delay short");
	chk_full_byte: assert property (two_wire_bus_mode && $rose(sda_oe) |-> sda_oe[*8] ##1 !sda_oe)
		else $error("byte not eight bits");
	chk_rate_sel: assert property (!$past(reset) |->
		slave_full_rate == ($past(master_frame_length) == $past(tx_param.fle))) else $error("rate flag wrong");
	cover property (bypass_load && upd_mode == 3'h7);
	cover property ($fell(slave_select_output));
	cover property ($rose(sda_oe));
endmodule
`default_nettype wire

// ---- testbench/sctc_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module sctc_partner
(
	input wire logic  clk_sys,
	input wire logic  clr,
	input wire logic  sda_out,
	input wire logic  sda_oe,
	output logic [7:0] rx_byte,
	output logic [3:0] rx_bits
);
	// ------------------------
	// Two-wire target receiver
	// ------------------------
	wire logic sda_line = sda_oe ? sda_out : 1'b1;
	always @(posedge clk_sys)
	begin
		if (clr)
			rx_bits <= 4'h0;
		else if (sda_oe)
		begin
			rx_byte <= {rx_byte[6:0], sda_line};
			rx_bits <= rx_bits + 4'h1;
		end
	end
endmodule
`default_nettype wire

// ---- testbench/serial_channel_transmit_control_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module serial_channel_transmit_control_tb_top;
	logic clk_sys, clk_link, reset, reset_link, synchronous_serial_mode, two_wire_bus_mode, bypass_load;
	logic transmit_buffer_wr, frame_start, status_clear_msls, tsif_clear, ack_end, clr;
	logic master_select_status, slave_select_output, transmit_shift_indication_flag;
	logic sda_out, sda_oe, sdo, slave_full_rate;
	logic [7:0] transmit_buffer_data, rx_byte;
	logic [3:0] rx_bits;
	logic [sctc_pkg::HOLD_DELAY_SETTING_W-1:0] hold_delay_setting;
	logic [sctc_pkg::FLE_W-1:0] master_frame_length;
	logic [31:0] rnd;
	sctc_pkg::sctc_upd_mode_s upd_mode;
	sctc_pkg::sctc_bypass_s bypass_in;
	sctc_pkg::sctc_tx_param_s tx_param, exp_p;
	sctc_pkg::sctc_tx_param_s note_q[$];
	int error_cnt, samples_checked, n;
	sctc_top u_dut (.*);
	sctc_partner u_far (.clk_sys, .clr, .sda_out, .sda_oe, .rx_byte, .rx_bits);
	// ----------------
	// Clocks and tasks
	// ----------------
	initial
	begin
		clk_sys = 0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	initial
	begin
		clk_link = 0;
		#3.7;
		forever #6 clk_link = ~clk_link;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
		samples_checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic pulse(ref logic sig);
		@(negedge clk_sys);
		sig = 1;
		@(negedge clk_sys);
		sig = 0;
	endtask
	task automatic wait_sel_low();
		n = 0;
		while (slave_select_output !== 1'b0 && n < 500)
		begin
			@(negedge clk_sys);
			n++;
		end
		chk("select wait", 0, n == 500);
		if (n == 500)
			give_verdict();
	endtask
	task automatic bypass(input logic [2:0] m, input logic s);
		rnd = lfsr(rnd);
		@(negedge clk_sys);
		upd_mode = m;
		synchronous_serial_mode = s;
		bypass_in = rnd[8:0];
		bypass_load = 1;
		if (m[2] && s)
			exp_p.ctr[20:16] = rnd[8:4];
		if (m[1])
		begin
			exp_p.eof = 1'b1;
			exp_p.wle = rnd[3:0];
		end
		if (m[0])
			exp_p.fle[4:0] = {1'b0, rnd[3:0]};
		note_q.push_back(exp_p);
	endtask
	// Result watcher for bypass loads
	always @(posedge clk_sys)
	begin
		if (bypass_load === 1'b1 && reset === 1'b0)
		begin
			@(negedge clk_sys);
			chk("tx_param", note_q.pop_front(), tx_param);
		end
	end
	// ----------------
	// Main sequence
	// ----------------
	initial
	begin
		{synchronous_serial_mode, two_wire_bus_mode, upd_mode, bypass_load, bypass_in} = '0;
		{transmit_buffer_wr, transmit_buffer_data, frame_start, status_clear_msls} = '0;
		{tsif_clear, hold_delay_setting, ack_end, clr, error_cnt, samples_checked} = '0;
		master_frame_length = 6'h07;
		reset = 1;
		reset_link = 1;
		rnd = 32'h0001_3c3d;
		exp_p = {2'h0, sctc_pkg::WLE_RST, sctc_pkg::FLE_RST, sctc_pkg::CTR_RST};
		repeat (20) @(negedge clk_sys);
		chk("reset tx_param", exp_p, tx_param);
		chk("reset outs", 3'h3, {master_select_status, sda_out, slave_full_rate});
		reset = 0;
		reset_link = 0;
		for (int i = 0; i < 16; i++)
			bypass(i[2:0], i[3]);
		@(negedge clk_sys);
		bypass_load = 0;
		master_frame_length = exp_p.fle;
		repeat (3) @(negedge clk_sys);
		chk("full rate", 1, slave_full_rate);
		master_frame_length = ~exp_p.fle;
		repeat (3) @(negedge clk_sys);
		chk("half rate", 0, slave_full_rate);
		pulse(tsif_clear);
		pulse(frame_start);
		transmit_buffer_data = rnd[7:0];
		pulse(transmit_buffer_wr);
		repeat (2) @(negedge clk_sys);
		pulse(status_clear_msls);
		wait_sel_low();
		chk("word done", 1, transmit_shift_indication_flag);
		chk("sdo rest", exp_p.wle > 4'h6 ? 1'b0 : transmit_buffer_data[6 - exp_p.wle], sdo);
		repeat (6) @(negedge clk_sys);
		pulse(tsif_clear);
		pulse(frame_start);
		pulse(status_clear_msls);
		wait_sel_low();
		chk("lead abort", 0, transmit_shift_indication_flag);
		synchronous_serial_mode = 0;
		two_wire_bus_mode = 1;
		for (int h = 0; h < 10; h += 5)
		begin
			hold_delay_setting = h[5:0];
			pulse(clr);
			rnd = lfsr(rnd);
			transmit_buffer_data = rnd[7:0];
			if (h == 0)
				pulse(transmit_buffer_wr);
			pulse(ack_end);
			if (h != 0)
				pulse(transmit_buffer_wr);
			n = 0;
			while (sda_oe !== 1'b1 && n < 100)
			begin
				@(negedge clk_sys);
				n++;
			end
			chk("hold gap", 1, n < 100 && n + 3 >= (h == 0 ? 4 : h));
			if (n == 100)
				give_verdict();
			repeat (12) @(negedge clk_sys);
			chk("rx byte", {4'h8, rnd[7:0]}, {rx_bits, rx_byte});
		end
		give_verdict();
	end
endmodule
bind sctc_top sctc_checker u_chk (.*);
`default_nettype wire
